// >>> rtl/adcctl_pkg.sv
// Purpose: Shared constants and types for the converter control block
// Assumes: 8-bit registers on a 32-bit classic Wishbone bus, one word each
// Notes: Offsets 0xD0 and 0xD1 are register indices; byte address is four times

package adcctl_pkg;

    // Register indices and byte addresses
    localparam logic [7:0] ADCCTL_IDX_RESULT = 8'hD0;
    localparam logic [7:0] ADCCTL_IDX_CONTROL = 8'hD1;
    localparam logic [7:0] ADCCTL_IDX_IRQ_STATUS = 8'hD2;
    localparam logic [7:0] ADCCTL_IDX_IRQ_MASK = 8'hD3;
    localparam logic [9:0] ADCCTL_ADDR_RESULT = {ADCCTL_IDX_RESULT, 2'b00};
    localparam logic [9:0] ADCCTL_ADDR_CONTROL = {ADCCTL_IDX_CONTROL, 2'b00};
    localparam logic [9:0] ADCCTL_ADDR_IRQ_STATUS = {ADCCTL_IDX_IRQ_STATUS, 2'b00};
    localparam logic [9:0] ADCCTL_ADDR_IRQ_MASK = {ADCCTL_IDX_IRQ_MASK, 2'b00};

    // Control register field positions
    localparam int ADCCTL_BIT_IRQ_EN = 7;
    localparam int ADCCTL_BIT_DONE = 6;
    localparam int ADCCTL_BIT_BEGIN = 5;
    localparam int ADCCTL_BIT_POWER = 4;
    localparam int ADCCTL_BIT_OSC_OFF = 2;

    // Reset values
    localparam logic [7:0] ADCCTL_CONTROL_RESET = 8'h40;
    localparam logic [7:0] ADCCTL_RESULT_RESET = 8'h00;

    // Interrupt status bit positions
    localparam int ADCCTL_IRQ_DONE = 0;
    localparam int ADCCTL_IRQ_WIDTH = 1;

    // Conversion timing: 70 us typical
    localparam int ADCCTL_CONV_TIME_NS = 70000;
    localparam int ADCCTL_CLK_PERIOD_NS = 10;
    localparam int ADCCTL_CONV_CYCLES = ADCCTL_CONV_TIME_NS / ADCCTL_CLK_PERIOD_NS;

    typedef struct packed {
        logic [9:0] addr;
        logic we;
        logic [3:0] sel;
        logic [31:0] wdata;
    } adcctl_req_t;

    typedef struct packed {
        logic start;
        logic powerOn;
    } adcctl_conv_cmd_t;

    typedef struct packed {
        logic done;
        logic [7:0] result;
    } adcctl_conv_rsp_t;

endpackage

// >>> rtl/adcctl_wb_slave.sv
// Purpose: Classic Wishbone slave front end, one-cycle registered ack
// Assumes: Master holds the request until ack is seen
// Notes: Emits a one-cycle access strobe when the request is taken

`timescale 1ns/1ns
`default_nettype none

module adcctl_wb_slave
    import adcctl_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_ack_o,
    // Register side
    output logic accessStrobe,
    output adcctl_req_t request
);

    wire requestLive = wb_cyc_i && wb_stb_i && !wb_ack_o;

    // Taken once; ack masks the strobe in its own cycle so a held request is not taken twice
    assign accessStrobe = requestLive;
    assign request = '{addr: wb_adr_i[9:0], we: wb_we_i, sel: wb_sel_i, wdata: wb_dat_i};

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= requestLive;
        end
    end

endmodule

`default_nettype wire

// >>> rtl/adcctl_timer.sv
// Purpose: Conversion sequencer standing in for the analog converter timing
// Assumes: Restart may arrive at any time and aborts the running count
// Notes: Done pulse is one cycle when the count expires with power on

`timescale 1ns/1ns
`default_nettype none

module adcctl_timer
    import adcctl_pkg::*;
#(
    parameter int CONV_CYCLES = ADCCTL_CONV_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Control
    input wire logic restart,
    input wire logic powerOn,
    // Status
    output logic busy,
    output logic expired
);

    localparam int CW = $clog2(CONV_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CONV_CYCLES - 1);

    logic [CW-1:0] count;

    wire atEnd = busy && (count == LAST);

    always_ff @(posedge clk_sys) begin
        if (reset || !powerOn) begin
            busy <= 1'b0;
            count <= '0;
            expired <= 1'b0;
        end else begin
            expired <= atEnd && !restart;
            if (restart) begin
                busy <= 1'b1;
                count <= '0;
            end else if (atEnd) begin
                busy <= 1'b0;
            end else if (busy) begin
                count <= count + CW'(1);
            end
        end
    end

endmodule

`default_nettype wire

// >>> rtl/adcctl_top.sv
// Purpose: Control and status logic of an 8-bit successive-approximation converter
// Assumes: Core clock 100 MHz, synchronous active-high reset, classic Wishbone
// Notes: Analog core result byte and done indication arrive as synchronous inputs
//
// Chosen here: register access over Wishbone.

`timescale 1ns/1ns
`default_nettype none

module adcctl_top
    import adcctl_pkg::*;
#(
    parameter int CONV_CYCLES = ADCCTL_CONV_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Analog converter core
    output adcctl_conv_cmd_t convCmd,
    input wire adcctl_conv_rsp_t convRsp,
    // Clock system and interrupt
    output logic mainOscDisable,
    output logic irq
);

    adcctl_req_t request;
    logic accessStrobe;
    logic ackInternal;

    adcctl_wb_slave u_slave (
        .clk_sys(clk_sys),
        .reset(reset),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_sel_i(wb_sel_i),
        .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i),
        .wb_ack_o(ackInternal),
        .accessStrobe(accessStrobe),
        .request(request)
    );

    assign wb_ack_o = ackInternal;

    // Control and status state
    logic doneIrqEnable;
    logic convDone;
    logic converterPowerOn;
    logic [7:0] conversionResult;
    logic [ADCCTL_IRQ_WIDTH-1:0] irqStatus;
    logic [ADCCTL_IRQ_WIDTH-1:0] irqMask;
    logic busy;
    logic expired;

    // Decode
    wire writeLow = accessStrobe && request.we && request.sel[0];
    wire hitControl = request.addr == ADCCTL_ADDR_CONTROL;
    wire hitResult = request.addr == ADCCTL_ADDR_RESULT;
    wire hitStatus = request.addr == ADCCTL_ADDR_IRQ_STATUS;
    wire hitMask = request.addr == ADCCTL_ADDR_IRQ_MASK;
    wire writeControl = writeLow && hitControl;
    wire [7:0] wByte = request.wdata[7:0];
    wire beginConversion = writeControl && wByte[ADCCTL_BIT_BEGIN];
    wire [ADCCTL_IRQ_WIDTH-1:0] statusClear = (writeLow && hitStatus)
        ? wByte[ADCCTL_IRQ_WIDTH-1:0] : '0;

    // Completion counts only from a powered, live conversion
    wire completion = convRsp.done && busy && converterPowerOn && !beginConversion;
    wire doneEvent = completion || expired;
    wire [ADCCTL_IRQ_WIDTH-1:0] irqSet = ADCCTL_IRQ_WIDTH'(doneEvent);

    // Busy stays low while powered off, so no result appears then
    // An early done from the core stops the count, so no second event follows
    adcctl_timer #(
        .CONV_CYCLES(CONV_CYCLES)
    ) u_timer (
        .clk_sys(clk_sys),
        .reset(reset),
        .restart(beginConversion && converterPowerOn),
        .powerOn(converterPowerOn && !completion),
        .busy(busy),
        .expired(expired)
    );

    // Control register write side; done flag is never written by software
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            doneIrqEnable <= ADCCTL_CONTROL_RESET[ADCCTL_BIT_IRQ_EN];
            converterPowerOn <= ADCCTL_CONTROL_RESET[ADCCTL_BIT_POWER];
            mainOscDisable <= ADCCTL_CONTROL_RESET[ADCCTL_BIT_OSC_OFF];
        end else if (writeControl) begin
            doneIrqEnable <= wByte[ADCCTL_BIT_IRQ_EN];
            converterPowerOn <= wByte[ADCCTL_BIT_POWER];
            mainOscDisable <= wByte[ADCCTL_BIT_OSC_OFF];
        end
    end

    // Done flag: set by hardware, cleared only by a start; set wins
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            convDone <= ADCCTL_CONTROL_RESET[ADCCTL_BIT_DONE];
        end else if (doneEvent) begin
            convDone <= 1'b1;
        end else if (beginConversion) begin
            convDone <= 1'b0;
        end
    end

    // Result loads with the flag and holds until the next completion
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            conversionResult <= ADCCTL_RESULT_RESET;
        end else if (doneEvent) begin
            conversionResult <= convRsp.result;
        end
    end

    // Sticky event status, write one to clear, set wins over clear
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irqStatus <= '0;
            irqMask <= '0;
        end else begin
            irqStatus <= (irqStatus & ~statusClear) | irqSet;
            if (writeLow && hitMask) begin
                irqMask <= wByte[ADCCTL_IRQ_WIDTH-1:0];
            end
        end
    end

    // Level request: the flag-based path follows the enable, so clearing the
    // enable alone silences it; the sticky path adds a mask for extra events
    wire next_irq = (doneIrqEnable && convDone)
        || |(irqStatus & irqMask);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= next_irq;
        end
    end

    // Commands to the analog core
    wire [1:0] next_cmd = {beginConversion && converterPowerOn, converterPowerOn};

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            convCmd <= '0;
        end else begin
            convCmd <= next_cmd;
        end
    end

    // Read mux; start bit and reserved bits read as zero
    wire [7:0] controlRead = {doneIrqEnable, convDone, 1'b0, converterPowerOn,
        1'b0, mainOscDisable, 2'b00};
    wire [31:0] next_rdata =
        hitControl ? {24'h00_0000, controlRead} :
        hitResult ? {24'h00_0000, conversionResult} :
        hitStatus ? {31'h0000_0000, irqStatus} :
        hitMask ? {31'h0000_0000, irqMask} :
        32'h0000_0000;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (accessStrobe && !request.we) begin
            wb_dat_o <= next_rdata;
        end
    end

endmodule

`default_nettype wire

// >>> sim/adcctl_checker.sv
// Purpose: Port-level assertions for the converter control block
// Assumes: One clock domain, sync active-high reset
// Notes: Read data is judged only while ack is high
`timescale 1ns/1ns
`default_nettype none
module adcctl_checker
    import adcctl_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Converter, clock system, interrupt
    input wire adcctl_conv_cmd_t convCmd,
    input wire adcctl_conv_rsp_t convRsp,
    input wire logic mainOscDisable,
    input wire logic irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    wire logic ackCtl = wb_cyc_i & wb_stb_i & wb_ack_o & (wb_adr_i[9:0] == ADCCTL_ADDR_CONTROL);
    wire logic wrCtl = ackCtl & wb_we_i & wb_sel_i[0];
    wire logic wrBegin = wrCtl & wb_dat_i[5];
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    ack_prompt_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered");
    begin_reads0_a: assert property (ackCtl && !wb_we_i |-> !wb_dat_o[5])
        else $error("begin bit read as one");
    upper_zero_a: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h00_0000)
        else $error("read data above bit 7");
    start_cause_a: assert property (convCmd.start |-> wrBegin)
        else $error("start without a begin write");
    start_sent_a: assert property (wrBegin && wb_dat_i[4] && convCmd.powerOn |-> convCmd.start)
        else $error("begin write lost");
    start_power_a: assert property (convCmd.start |-> $past(convCmd.powerOn))
        else $error("start while unpowered");
    start_pulse_a: assert property (convCmd.start |=> !convCmd.start)
        else $error("start pulse too long");
    osc_cause_a: assert property ($changed(mainOscDisable) |-> wrCtl)
        else $error("oscillator bit moved alone");
    power_cause_a: assert property ($changed(convCmd.powerOn) |-> $past(wrCtl) || $past(wrCtl, 2))
        else $error("power bit moved alone");
    reset_quiet_a: assert property ($fell(reset) |-> !wb_ack_o && !irq && !convCmd.start)
        else $error("outputs busy after reset");
endmodule
`default_nettype wire

// >>> sim/adcctl_core_model.sv
// Purpose: Behavioural analog converter core
// Assumes: Result byte is latched from the bench sample at each start
// Notes: Early mode pulses done before the sequencer would expire
`timescale 1ns/1ns
`default_nettype none
module adcctl_core_model
    import adcctl_pkg::*;
(
    // Clock
    input wire logic clk_sys,
    // Converter command and answer
    input wire adcctl_conv_cmd_t convCmd,
    output adcctl_conv_rsp_t convRsp,
    // Bench controls
    input wire logic [7:0] sample,
    input wire logic early
);
    logic [7:0] held = 8'h00;
    logic [3:0] count = 4'h0;
    always_ff @(posedge clk_sys) begin
        if (convCmd.start) begin
            held <= sample;
            count <= early ? 4'h5 : 4'h0;
        end else if (count != 4'h0) begin
            count <= count - 4'h1;
        end
    end
    // Unpowered core shows a wrong byte so a stale load cannot pass
    assign convRsp = {count == 4'h1, convCmd.powerOn ? held : ~held};
endmodule
`default_nettype wire

// >>> sim/adc_control_status_logic_test.sv
// Purpose: Self-checking bench for the converter control block
// Assumes: Sequencer shortened to CONV cycles
// Notes: Bus replies are sampled at the rising edge, outputs after tick on the falling edge
`timescale 1ns/1ns
`default_nettype none
module adc_control_status_logic_test
    import adcctl_pkg::*;
();
    localparam int CONV = 20;
    localparam logic [9:0] CTRL = ADCCTL_ADDR_CONTROL;
    localparam logic [9:0] RES = ADCCTL_ADDR_RESULT;
    localparam logic [9:0] STAT = ADCCTL_ADDR_IRQ_STATUS;
    localparam logic [9:0] MASK = ADCCTL_ADDR_IRQ_MASK;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic wbCyc = 1'b0;
    logic wbStb = 1'b0;
    logic wbWe = 1'b0;
    logic [3:0] wbSel = 4'hF;
    logic [3:0] selNext = 4'hF;
    logic [31:0] wbAdr = 32'h0000_0000;
    logic [31:0] wbDat = 32'h0000_0000;
    logic [31:0] wbDatOut;
    logic wbAck;
    logic mainOscDisable;
    logic irq;
    adcctl_conv_cmd_t convCmd;
    adcctl_conv_rsp_t convRsp;
    logic [7:0] sample = 8'h3C;
    logic early = 1'b0;
    logic [7:0] rd;
    int err_total = 0;
    int n_compared = 0;
    always #5 clk_sys = ~clk_sys;
    adcctl_top #(.CONV_CYCLES(CONV)) u_dut (.clk_sys(clk_sys), .reset(reset), .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_sel_i(wbSel), .wb_adr_i(wbAdr), .wb_dat_i(wbDat),
        .wb_dat_o(wbDatOut), .wb_ack_o(wbAck), .convCmd(convCmd), .convRsp(convRsp),
        .mainOscDisable(mainOscDisable), .irq(irq));
    adcctl_core_model u_model (.clk_sys(clk_sys), .convCmd(convCmd), .convRsp(convRsp),
        .sample(sample), .early(early));
    task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task xfer(input logic [9:0] a, input logic w, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= w;
        wbSel <= selNext;
        wbAdr <= {22'h00_0000, a};
        wbDat <= {24'h00_0000, d};
        do begin
            @(posedge clk_sys);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        rd = wbDatOut[7:0];
        chk({7'h00, wbAck}, 8'h01, "ack");
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
    endtask
    task rdchk(input logic [9:0] a, input logic [7:0] exp, input string what);
        xfer(a, 1'b0, 8'h00);
        chk(rd, exp, what);
    endtask
    task tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task test_reset;
        rdchk(CTRL, 8'h40, "control reset");
        chk({7'h00, mainOscDisable}, 8'h00, "osc reset");
        chk({6'h00, convCmd}, 8'h00, "cmd reset");
        rdchk(10'h3FC, 8'h00, "unmapped read");
        $display("test_reset done");
    endtask
    task test_convert;
        xfer(CTRL, 1'b1, 8'h10);
        tick(2);
        chk({7'h00, convCmd.powerOn}, 8'h01, "power on");
        xfer(CTRL, 1'b1, 8'h30);
        rdchk(CTRL, 8'h10, "done cleared");
        tick(CONV);
        rdchk(CTRL, 8'h50, "done set");
        rdchk(RES, 8'h3C, "result");
        xfer(CTRL, 1'b1, 8'h10);
        rdchk(CTRL, 8'h50, "done kept");
        xfer(RES, 1'b1, 8'hFF);
        rdchk(RES, 8'h3C, "result read-only");
        $display("test_convert done");
    endtask
    task test_restart;
        sample <= 8'hC3;
        xfer(CTRL, 1'b1, 8'h30);
        tick(12);
        sample <= 8'h5A;
        xfer(CTRL, 1'b1, 8'h30);
        tick(8);
        rdchk(CTRL, 8'h10, "first aborted");
        tick(CONV);
        rdchk(CTRL, 8'h50, "second done");
        rdchk(RES, 8'h5A, "fresh result");
        early <= 1'b1;
        xfer(CTRL, 1'b1, 8'h30);
        tick(8);
        rdchk(CTRL, 8'h50, "early done");
        early <= 1'b0;
        $display("test_restart done");
    endtask
    task test_irq;
        xfer(CTRL, 1'b1, 8'h90);
        tick(2);
        chk({7'h00, irq}, 8'h01, "irq with flag");
        xfer(CTRL, 1'b1, 8'hB0);
        tick(2);
        chk({7'h00, irq}, 8'h00, "irq cleared by begin");
        tick(CONV);
        chk({7'h00, irq}, 8'h01, "irq at done");
        xfer(CTRL, 1'b1, 8'h10);
        tick(2);
        chk({7'h00, irq}, 8'h00, "irq disabled");
        rdchk(STAT, 8'h01, "status sticky");
        xfer(MASK, 1'b1, 8'h01);
        tick(2);
        chk({7'h00, irq}, 8'h01, "masked irq");
        xfer(STAT, 1'b1, 8'h01);
        tick(2);
        chk({7'h00, irq}, 8'h00, "status cleared");
        xfer(MASK, 1'b1, 8'h00);
        $display("test_irq done");
    endtask
    task test_power_osc;
        xfer(CTRL, 1'b1, 8'h00);
        xfer(CTRL, 1'b1, 8'h20);
        tick(CONV + 5);
        rdchk(CTRL, 8'h00, "unpowered begin");
        xfer(CTRL, 1'b1, 8'h04);
        tick(2);
        chk({7'h00, mainOscDisable}, 8'h01, "osc off");
        chk({6'h00, convCmd}, 8'h00, "core untouched");
        // A write without the low byte lane must leave the control byte alone
        selNext = 4'hE;
        xfer(CTRL, 1'b1, 8'h00);
        selNext = 4'hF;
        rdchk(CTRL, 8'h04, "low lane off ignored");
        $display("test_power_osc done");
    endtask
    task end_sim;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        test_reset;
        test_convert;
        test_restart;
        test_irq;
        test_power_osc;
        end_sim;
    end
    // Tests need well under a thousand cycles
    initial begin
        #50000;
        err_total++;
        $display("mismatch at %0t: watchdog", $time);
        end_sim;
    end
endmodule
bind adcctl_top adcctl_checker u_chk (.clk_sys(clk_sys), .reset(reset), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .convCmd(convCmd),
    .convRsp(convRsp), .mainOscDisable(mainOscDisable), .irq(irq));
`default_nettype wire
